// [core/pld_lock_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module pld_lock_counter #(
	parameter int CNT_W = 14
) (
	// clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     reset_n,
	// configuration
	input  wire logic [CNT_W-1:0]         threshold,
	input  wire logic [pld_pkg::WIN_W-1:0] windowCode,
	// phase comparisons
	input  wire logic                     cmpValid,
	input  wire logic [pld_pkg::ERR_W-1:0] phaseErrNs,
	// result
	output logic                          locked
);
	import pld_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [CNT_W-1:0] count;  // consecutive in-window comparisons
		logic             locked; // digital lock flag
	} pld_lc_state_t;

	pld_lc_state_t stQ;  // registered state
	pld_lc_state_t stD;  // next state
	logic          inWin; // this comparison is inside the window
	logic [CNT_W-1:0] cntInc; // count plus one

	assign inWin  = phaseErrNs < win_ns(windowCode);
	assign cntInc = CNT_W'(stQ.count + 1'b1);
	assign locked = stQ.locked;

	// next state: count while in window, drop on any miss
	always_comb begin
		stD = stQ;
		if (cmpValid) begin
			if (inWin) begin
				// saturate so a long lock never wraps back to zero
				if (stQ.count != {CNT_W{1'b1}}) begin
					stD.count = cntInc;
				end
				if (cntInc >= threshold) begin
					stD.locked = 1'b1;
				end
			end else begin
				stD.count  = '0;
				stD.locked = 1'b0;
			end
		end
	end

	// register the state
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			stQ <= '0;
		end else begin
			stQ <= stD;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	a_miss_clears: assert property (cmpValid && !inWin |=> !locked && stQ.count == '0)
		else $error("lock not dropped on window miss");
	a_lock_needs_count: assert property ($rose(locked) |-> $past(cmpValid) && stQ.count >= threshold)
		else $error("lock rose before threshold reached");
	a_count_steps: assert property (cmpValid && inWin && stQ.count < threshold |=> stQ.count == $past(stQ.count) + 1'b1)
		else $error("lock counter did not step");
	a_count_holds: assert property (!cmpValid |=> $stable(stQ.count) && $stable(locked))
		else $error("lock state moved without a comparison");
	c_lock_gained: cover property ($rose(locked));
endmodule
`default_nettype wire

// [core/pld_status_cfg.sv]
// Functional notes
// - 14-bit lock threshold split over two registers
// - lock only after threshold consecutive good comparisons
// - count in-window comparisons, window 4/9/19/43 ns
// - holdover exit restarts reference and feedback dividers
// - signed 5-bit offset skews the two restarts
// - selector bits 7:3 pick status pin source
// - codes 11..18 route divider taps and halves
// - type bits 2:0 set pin input/output mode
// - 12-bit second reference divide split over two
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pld_status_cfg (
	// clock and reset
	input  wire logic                         clk_sys,
	input  wire logic                         reset_n,
	// register port
	input  wire logic [pld_pkg::ADDR_W-1:0]   regAddr,
	input  wire logic [pld_pkg::DATA_W-1:0]   regWdata,
	input  wire logic                         regWr,
	input  wire logic                         regRd,
	output logic      [pld_pkg::DATA_W-1:0]   regRdata,
	// phase detector of the first loop
	input  wire logic                         cmpValid,
	input  wire logic [pld_pkg::ERR_W-1:0]    phaseErrNs,
	// surrounding device state
	input  wire logic                         holdoverActive,
	input  wire logic                         secondLock,
	input  wire logic                         dacLocked,
	input  wire logic                         dacRail,
	input  wire logic                         dacLow,
	input  wire logic                         dacHigh,
	input  wire logic                         readbackBit,
	// divider output taps
	input  wire logic                         firstFbTap,
	input  wire logic                         secondFbTap,
	input  wire logic                         firstRefTap,
	input  wire logic                         secondRefTap,
	// divider restart and configuration
	output logic                              firstRefReset,
	output logic                              firstFbReset,
	output logic      [pld_pkg::R2_W-1:0]     secondRefDivide,
	// status pin
	input  wire logic                         pinIn,
	output logic                              pinOut,
	output logic                              pinOe,
	output logic                              pinPullUp,
	output logic                              pinPullDown,
	output logic                              thirdClockLos,
	// lock and interrupt
	output logic                              firstLock,
	output logic                              irq
);
	import pld_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [THR_HI_W-1:0] thrHi;     // threshold upper bits
		logic [7:0]          thrLo;     // threshold lower bits
		logic [ADJ_W-1:0]    exitAdj;   // holdover exit offset
		logic [4:0]          srcSel;    // status pin source
		logic [2:0]          ioType;    // status pin mode
		logic [R2_HI_W-1:0]  r2Hi;      // second ref divide upper
		logic [7:0]          r2Lo;      // second ref divide lower
		logic [WIN_W-1:0]    window;    // phase window code
		logic [IRQ_W-1:0]    irqStat;   // sticky events
		logic [IRQ_W-1:0]    irqMask;   // event enables
		logic [DATA_W-1:0]   rdata;     // read data, one cycle late
		logic                hoPrev;    // holdover last cycle
		logic                lockPrev;  // lock last cycle
		logic                losPrev;   // loss-of-signal last cycle
		logic                los;       // sampled loss-of-signal
		pld_exit_t           exState;   // restart sequencer
		logic [ADJ_W-1:0]    exCount;   // cycles left before second restart
		logic                refRst;    // reference divider restart
		logic                fbRst;     // feedback divider restart
		logic [3:0]          tapPrev;   // divider taps last cycle
		logic [3:0]          tapHalf;   // divided-by-two taps
		logic                pinOut;    // pin output level
		logic                pinOe;     // pin drive enable
	} pld_state_t;

	pld_state_t stQ;      // registered state
	pld_state_t stD;      // next state
	logic [3:0] taps;     // taps in order fb1, fb2, ref1, ref2
	logic       srcVal;   // selected source level
	logic       lockNow;  // lock from the counter
	logic [IRQ_W-1:0] evt; // events this cycle
	logic signed [ADJ_W-1:0] adjS; // offset as signed

	assign taps = {secondRefTap, firstRefTap, secondFbTap, firstFbTap};
	assign adjS = $signed(stQ.exitAdj);

	// ---------------------------------------------------------------
	// lock counter
	// ---------------------------------------------------------------
	pld_lock_counter #(
		.CNT_W     (CNT_W)
	) pld_lock_counter_inst (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.threshold ({stQ.thrHi, stQ.thrLo}),
		.windowCode(stQ.window),
		.cmpValid  (cmpValid),
		.phaseErrNs(phaseErrNs),
		.locked    (lockNow)
	);

	// ---------------------------------------------------------------
	// source selection
	// ---------------------------------------------------------------
	// pick the level the status pin reports
	always_comb begin
		case (pld_src_t'(stQ.srcSel))
			SRC_LOW:        srcVal = 1'b0;
			SRC_LOCK1:      srcVal = lockNow;
			SRC_LOCK2:      srcVal = secondLock;
			SRC_LOCK_BOTH:  srcVal = lockNow & secondLock;
			SRC_HOLDOVER:   srcVal = holdoverActive;
			SRC_DAC_LOCKED: srcVal = dacLocked;
			SRC_READBACK:   srcVal = readbackBit;
			SRC_DAC_RAIL:   srcVal = dacRail;
			SRC_DAC_LOW:    srcVal = dacLow;
			SRC_DAC_HIGH:   srcVal = dacHigh;
			SRC_FB1:        srcVal = firstFbTap;
			SRC_FB1_HALF:   srcVal = stQ.tapHalf[0];
			SRC_FB2:        srcVal = secondFbTap;
			SRC_FB2_HALF:   srcVal = stQ.tapHalf[1];
			SRC_REF1:       srcVal = firstRefTap;
			SRC_REF1_HALF:  srcVal = stQ.tapHalf[2];
			// shares a path with the second pin's lock source
			SRC_REF2:       srcVal = secondRefTap;
			SRC_REF2_HALF:  srcVal = stQ.tapHalf[3];
			// reserved and undefined codes select a low source level
			default:        srcVal = 1'b0;
		endcase
	end

	// events that feed the sticky status
	always_comb begin
		evt = '0;
		evt[IRQ_LOCK_GAIN] = lockNow & ~stQ.lockPrev;
		evt[IRQ_LOCK_LOST] = ~lockNow & stQ.lockPrev;
		evt[IRQ_HO_EXIT]   = stQ.hoPrev & ~holdoverActive;
		evt[IRQ_LOS_RISE]  = stQ.los & ~stQ.losPrev;
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		stD = stQ;
		stD.hoPrev   = holdoverActive;
		stD.lockPrev = lockNow;
		stD.losPrev  = stQ.los;
		stD.tapPrev  = taps;
		stD.refRst   = 1'b0;
		stD.fbRst    = 1'b0;
		stD.rdata    = '0;

		// halves toggle on each rising tap edge
		for (int i = 0; i < 4; i++) begin
			if (taps[i] && !stQ.tapPrev[i]) begin
				stD.tapHalf[i] = ~stQ.tapHalf[i];
			end
		end

		// pin mode decides drive and what is sensed
		case (pld_io_t'(stQ.ioType))
			IO_LOS_IN, IO_LOS_PU, IO_LOS_PD: begin
				stD.pinOe  = 1'b0;
				stD.pinOut = 1'b0;
				stD.los    = pinIn;
			end
			IO_PUSH: begin
				stD.pinOe  = 1'b1;
				stD.pinOut = srcVal;
				stD.los    = 1'b0;
			end
			IO_PUSH_INV: begin
				stD.pinOe  = 1'b1;
				stD.pinOut = ~srcVal;
				stD.los    = 1'b0;
			end
			IO_OPEN_DRAIN: begin
				// pull low for a zero, release for a one
				stD.pinOe  = ~srcVal;
				stD.pinOut = 1'b0;
				stD.los    = 1'b0;
			end
			default: begin
				// reserved mode leaves the pin floating
				stD.pinOe  = 1'b0;
				stD.pinOut = 1'b0;
				stD.los    = 1'b0;
			end
		endcase

		// holdover exit restarts both dividers, one skewed
		case (stQ.exState)
			EX_IDLE: begin
				if (evt[IRQ_HO_EXIT]) begin
					if (adjS == '0) begin
						stD.refRst = 1'b1;
						stD.fbRst  = 1'b1;
					end else if (adjS > 0) begin
						// reference first, feedback after the offset
						stD.refRst  = 1'b1;
						stD.exCount = stQ.exitAdj;
						stD.exState = EX_WAIT_FB;
					end else begin
						// feedback first, reference after the offset
						stD.fbRst   = 1'b1;
						stD.exCount = ADJ_W'(-adjS);
						stD.exState = EX_WAIT_REF;
					end
				end
			end
			EX_WAIT_FB: begin
				stD.exCount = ADJ_W'(stQ.exCount - 1'b1);
				if (stQ.exCount == ADJ_W'(1)) begin
					stD.fbRst   = 1'b1;
					stD.exState = EX_IDLE;
				end
			end
			EX_WAIT_REF: begin
				stD.exCount = ADJ_W'(stQ.exCount - 1'b1);
				if (stQ.exCount == ADJ_W'(1)) begin
					stD.refRst  = 1'b1;
					stD.exState = EX_IDLE;
				end
			end
			default: begin
				stD.exState = EX_IDLE;
			end
		endcase

		// register writes; reserved bits are not stored
		if (regWr) begin
			case (regAddr)
				OFF_THR_HI:   stD.thrHi   = regWdata[THR_HI_W-1:0];
				OFF_THR_LO:   stD.thrLo   = regWdata;
				OFF_EXIT_ADJ: stD.exitAdj = regWdata[ADJ_W-1:0];
				OFF_PIN_CFG: begin
					stD.srcSel = regWdata[SEL_MSB:SEL_LSB];
					stD.ioType = regWdata[TYPE_MSB:TYPE_LSB];
				end
				OFF_R2_HI:    stD.r2Hi    = regWdata[R2_HI_W-1:0];
				OFF_R2_LO:    stD.r2Lo    = regWdata;
				OFF_IRQ_STAT: stD.irqStat = stQ.irqStat & ~regWdata[IRQ_W-1:0];
				OFF_IRQ_MASK: stD.irqMask = regWdata[IRQ_W-1:0];
				OFF_WINDOW:   stD.window  = regWdata[WIN_W-1:0];
				default: begin
					// unmapped writes are dropped
				end
			endcase
		end
		// a new event wins over a clear in the same cycle
		stD.irqStat = stD.irqStat | evt;

		// register reads, answered next cycle
		if (regRd) begin
			case (regAddr)
				OFF_THR_HI:   stD.rdata = DATA_W'(stQ.thrHi);
				OFF_THR_LO:   stD.rdata = stQ.thrLo;
				OFF_EXIT_ADJ: stD.rdata = DATA_W'(stQ.exitAdj);
				OFF_PIN_CFG:  stD.rdata = {stQ.srcSel, stQ.ioType};
				OFF_R2_HI:    stD.rdata = DATA_W'(stQ.r2Hi);
				OFF_R2_LO:    stD.rdata = stQ.r2Lo;
				OFF_IRQ_STAT: stD.rdata = DATA_W'(stQ.irqStat);
				OFF_IRQ_MASK: stD.rdata = DATA_W'(stQ.irqMask);
				OFF_LIVE:     stD.rdata = DATA_W'({stQ.los, holdoverActive, lockNow});
				OFF_WINDOW:   stD.rdata = DATA_W'(stQ.window);
				default:      stD.rdata = '0;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			stQ         <= '0;
			stQ.thrHi   <= RST_THR_HI;
			stQ.thrLo   <= RST_THR_LO;
			stQ.exitAdj <= RST_EXIT_ADJ;
			stQ.srcSel  <= RST_SRC_SEL;
			stQ.ioType  <= RST_IO_TYPE;
			stQ.r2Hi    <= RST_R2_HI;
			stQ.r2Lo    <= RST_R2_LO;
			stQ.window  <= RST_WINDOW;
			stQ.exState <= EX_IDLE;
			// taps already high at release must not look like a rising edge
			stQ.tapPrev <= '1;
		end else begin
			stQ <= stD;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign regRdata        = stQ.rdata;
	assign firstRefReset   = stQ.refRst;
	assign firstFbReset    = stQ.fbRst;
	assign secondRefDivide = {stQ.r2Hi, stQ.r2Lo};
	assign pinOut          = stQ.pinOut;
	assign pinOe           = stQ.pinOe;
	// pulls are static from the mode, no timing hazard
	assign pinPullUp       = stQ.ioType == IO_LOS_PU;
	assign pinPullDown     = stQ.ioType == IO_LOS_PD;
	assign thirdClockLos   = stQ.los;
	assign firstLock       = lockNow;
	assign irq             = |(stQ.irqStat & stQ.irqMask);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	a_exit_restart: assert property ($fell(holdoverActive) && stQ.exState == EX_IDLE && adjS == '0
		|=> firstRefReset && firstFbReset)
		else $error("zero offset exit did not restart both dividers");
	a_exit_skew: assert property ($fell(holdoverActive) && stQ.exState == EX_IDLE && adjS == 5'sd2
		|=> firstRefReset && !firstFbReset ##1 !firstFbReset ##1 firstFbReset)
		else $error("feedback restart not delayed by the offset");
	a_pin_select: assert property (regWr && regAddr == OFF_PIN_CFG
		|=> stQ.srcSel == $past(regWdata[SEL_MSB:SEL_LSB]))
		else $error("source select not taken from bits 7:3");
	a_lock_drive: assert property (stQ.srcSel == SRC_LOCK1 && stQ.ioType == IO_PUSH
		&& $stable(stQ.srcSel) && $stable(stQ.ioType) |=> pinOe && pinOut == $past(lockNow))
		else $error("push-pull pin does not follow lock");
	// the cycle right after reset still shows the reset drive, so it is skipped
	a_od_release: assert property (stQ.ioType == IO_OPEN_DRAIN && $stable(stQ.ioType) && $past(reset_n)
		|-> !pinOut && pinOe == !$past(srcVal))
		else $error("open-drain pin driven wrongly");
	a_input_float: assert property (stQ.ioType <= IO_LOS_PD && $stable(stQ.ioType) |-> !pinOe)
		else $error("input mode drives the pin");
	a_half_toggle: assert property (firstFbTap && !stQ.tapPrev[0] |=> stQ.tapHalf[0] != $past(stQ.tapHalf[0]))
		else $error("feedback half tap did not toggle");
	a_thr_width: assert property (regWr && regAddr == OFF_THR_HI ##1 !regWr
		##1 regRd && regAddr == OFF_THR_HI |=> regRdata == {2'b00, $past(regWdata[THR_HI_W-1:0], 3)})
		else $error("threshold upper register readback wrong");
	a_r2_value: assert property (regWr && regAddr == OFF_R2_HI
		|=> secondRefDivide[R2_W-1:R2_W-R2_HI_W] == $past(regWdata[R2_HI_W-1:0]))
		else $error("second reference divide high bits not stored");
	// an event always lands in the sticky status, even beside a clear
	a_irq_sticky: assert property (evt != '0 |=> (stQ.irqStat & $past(evt)) == $past(evt))
		else $error("event lost from interrupt status");
	c_exit_seen: cover property ($fell(holdoverActive) ##[1:40] firstFbReset);
	c_lock_irq: cover property (lockNow && irq);
	c_los_rise: cover property ($rose(thirdClockLos));
endmodule
`default_nettype wire

// [inc/pld_pkg.sv]
// ---------------------------------------------------------------
// shared constants for the first-loop lock / status pin block
// ---------------------------------------------------------------
package pld_pkg;

	// register port geometry
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam int CNT_W  = 14;
	localparam int R2_W   = 12;
	localparam int ADJ_W  = 5;
	localparam int ERR_W  = 8;

	// register offsets (byte addresses on the plain port)
	localparam logic [ADDR_W-1:0] OFF_THR_HI   = 9'h15c;
	localparam logic [ADDR_W-1:0] OFF_THR_LO   = 9'h15d;
	localparam logic [ADDR_W-1:0] OFF_EXIT_ADJ = 9'h15e;
	localparam logic [ADDR_W-1:0] OFF_PIN_CFG  = 9'h15f;
	localparam logic [ADDR_W-1:0] OFF_R2_HI    = 9'h160;
	localparam logic [ADDR_W-1:0] OFF_R2_LO    = 9'h161;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 9'h170;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 9'h171;
	localparam logic [ADDR_W-1:0] OFF_LIVE     = 9'h172;
	localparam logic [ADDR_W-1:0] OFF_WINDOW   = 9'h173;

	// field positions
	localparam int THR_HI_W = 6;
	localparam int R2_HI_W  = 4;
	localparam int SEL_MSB  = 7;
	localparam int SEL_LSB  = 3;
	localparam int TYPE_MSB = 2;
	localparam int TYPE_LSB = 0;
	localparam int WIN_W    = 2;

	// reset values
	localparam logic [THR_HI_W-1:0] RST_THR_HI   = 6'h20;
	localparam logic [7:0]          RST_THR_LO   = 8'h00;
	localparam logic [ADJ_W-1:0]    RST_EXIT_ADJ = 5'h1e;
	localparam logic [4:0]          RST_SRC_SEL  = 5'h01;
	localparam logic [2:0]          RST_IO_TYPE  = 3'h6;
	localparam logic [R2_HI_W-1:0]  RST_R2_HI    = 4'h0;
	localparam logic [7:0]          RST_R2_LO    = 8'h02;
	localparam logic [WIN_W-1:0]    RST_WINDOW   = 2'h3;

	// phase-error windows in ns
	localparam logic [ERR_W-1:0] WIN0_NS = 8'h04;
	localparam logic [ERR_W-1:0] WIN1_NS = 8'h09;
	localparam logic [ERR_W-1:0] WIN2_NS = 8'h13;
	localparam logic [ERR_W-1:0] WIN3_NS = 8'h2b;

	// interrupt bit positions
	localparam int IRQ_W         = 4;
	localparam int IRQ_LOCK_GAIN = 0;
	localparam int IRQ_LOCK_LOST = 1;
	localparam int IRQ_HO_EXIT   = 2;
	localparam int IRQ_LOS_RISE  = 3;

	// status pin source codes
	typedef enum logic [4:0] {
		SRC_LOW = 5'h00, SRC_LOCK1 = 5'h01, SRC_LOCK2 = 5'h02, SRC_LOCK_BOTH = 5'h03,
		SRC_HOLDOVER = 5'h04, SRC_DAC_LOCKED = 5'h05, SRC_RSVD = 5'h06, SRC_READBACK = 5'h07,
		SRC_DAC_RAIL = 5'h08, SRC_DAC_LOW = 5'h09, SRC_DAC_HIGH = 5'h0a,
		SRC_FB1 = 5'h0b, SRC_FB1_HALF = 5'h0c, SRC_FB2 = 5'h0d, SRC_FB2_HALF = 5'h0e,
		SRC_REF1 = 5'h0f, SRC_REF1_HALF = 5'h10, SRC_REF2 = 5'h11, SRC_REF2_HALF = 5'h12
	} pld_src_t;

	// status pin electrical modes
	typedef enum logic [2:0] {
		IO_LOS_IN = 3'h0, IO_LOS_PU = 3'h1, IO_LOS_PD = 3'h2, IO_PUSH = 3'h3,
		IO_PUSH_INV = 3'h4, IO_RSVD = 3'h5, IO_OPEN_DRAIN = 3'h6
	} pld_io_t;

	// holdover exit sequencer, one-hot
	typedef enum logic [2:0] {
		EX_IDLE = 3'b001, EX_WAIT_REF = 3'b010, EX_WAIT_FB = 3'b100
	} pld_exit_t;

	// window code to ns
	function automatic logic [ERR_W-1:0] win_ns(input logic [WIN_W-1:0] code);
		case (code)
			2'h0: win_ns = WIN0_NS;
			2'h1: win_ns = WIN1_NS;
			2'h2: win_ns = WIN2_NS;
			default: win_ns = WIN3_NS;
		endcase
	endfunction

endpackage

// [sim/pld_pin_partner.sv]
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// board side of the status pin
// ---------------------------------------------
module pld_pin_partner (
	// design side of the pin
	input  wire logic pinOut,
	input  wire logic pinOe,
	input  wire logic pinPullUp,
	input  wire logic pinPullDown,
	// external loss-of-signal source
	input  wire logic driveEn,
	input  wire logic driveLvl,
	// resolved wire level
	output logic      pinLevel
);
	// wire resolution: design driver first, then the external source, then pulls; an undriven line sits on the board pull-up
	// unless the internal pull-down is on, so an open-drain high is never read from a stale value
	always_comb begin
		if (pinOe)
			pinLevel = pinOut;
		else if (driveEn)
			pinLevel = driveLvl;
		else
			pinLevel = pinPullUp || !pinPullDown;
	end
endmodule
`default_nettype wire

// [sim/pld_status_cfg_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pld_status_cfg_tb_top;
	import pld_pkg::*;
	// ---------------------------------------------
	// stimulus and observed signals
	// ---------------------------------------------
	logic              clk_sys = 0, reset_n = 0, regWr = 0, regRd = 0, cmpValid = 0, holdoverActive = 0;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWdata = '0, regRdata;
	logic [ERR_W-1:0]  phaseErrNs = '0;
	logic              secondLock = 1, dacLocked = 1, dacRail = 0, dacLow = 0, dacHigh = 1, readbackBit = 1;
	logic              firstFbTap = 1, secondFbTap = 0, firstRefTap = 0, secondRefTap = 0, driveEn = 0;
	logic              firstRefReset, firstFbReset, pinOut, pinOe, pinPullUp, pinPullDown, pinLevel;
	logic              thirdClockLos, firstLock, irq;
	logic [R2_W-1:0]   secondRefDivide;
	int                nFail = 0, testsRun = 0, cyc = 0, tf, tr, nf, nr;
	// reset table: address and expected byte, last one unmapped
	localparam logic [ADDR_W-1:0] RA [10] = '{OFF_THR_HI, OFF_THR_LO, OFF_EXIT_ADJ, OFF_PIN_CFG, OFF_R2_HI,
		OFF_R2_LO, OFF_IRQ_STAT, OFF_IRQ_MASK, OFF_WINDOW, 9'h100};
	localparam logic [7:0] RV [10] = '{8'h20, 8'h00, 8'h1e, 8'h0e, 8'h00, 8'h02, 8'h00, 8'h00, 8'h03, 8'h00};
	// lock steps: window code, phase error, expected lock
	localparam logic [10:0] LK [12] = '{11'h006, 11'h007, 11'h008, 11'h006, 11'h007, 11'h655, 11'h656,
		11'h210, 11'h211, 11'h426, 11'h424, 11'h425};
	// pin steps: expected level, pin config byte
	localparam logic [8:0] PT [26] = '{9'h10b, 9'h003, 9'h00c, 9'h104, 9'h10e, 9'h006, 9'h113, 9'h11b, 9'h023,
		9'h12b, 9'h033, 9'h13b, 9'h043, 9'h04b, 9'h153, 9'h15b, 9'h07b, 9'h109, 9'h108, 9'h00a,
		9'h063, 9'h06b, 9'h073, 9'h083, 9'h08b, 9'h093};

	// ---------------------------------------------
	// design and board model
	// ---------------------------------------------
	pld_status_cfg pld_status_cfg_inst (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cmpValid(cmpValid),
		.phaseErrNs(phaseErrNs), .holdoverActive(holdoverActive), .secondLock(secondLock),
		.dacLocked(dacLocked), .dacRail(dacRail), .dacLow(dacLow), .dacHigh(dacHigh),
		.readbackBit(readbackBit), .firstFbTap(firstFbTap), .secondFbTap(secondFbTap),
		.firstRefTap(firstRefTap), .secondRefTap(secondRefTap), .firstRefReset(firstRefReset),
		.firstFbReset(firstFbReset), .secondRefDivide(secondRefDivide), .pinIn(pinLevel), .pinOut(pinOut),
		.pinOe(pinOe), .pinPullUp(pinPullUp), .pinPullDown(pinPullDown), .thirdClockLos(thirdClockLos),
		.firstLock(firstLock), .irq(irq));
	pld_pin_partner pld_pin_partner_inst (.pinOut(pinOut), .pinOe(pinOe), .pinPullUp(pinPullUp),
		.pinPullDown(pinPullDown), .driveEn(driveEn), .driveLvl(1'b1), .pinLevel(pinLevel));

	// ---------------------------------------------
	// clock, watchdog and helper tasks
	// ---------------------------------------------
	always #20 clk_sys = ~clk_sys;
	// watchdog: the whole run needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			nFail++;
			print_verdict();
		end
	end
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", testsRun, nFail);
		if (nFail == 0 && testsRun > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		testsRun++;
		if (got !== exp) begin
			nFail++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] got, input logic [7:0] exp);
		chk({4'h0, got}, {4'h0, exp});
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWr <= 1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk_sys);
		regWr <= 0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		regRd <= 1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 0;
		#1 rchk(regRdata, exp);
	endtask
	task automatic cmp(input logic [7:0] e);
		@(posedge clk_sys);
		cmpValid <= 1;
		phaseErrNs <= e;
		@(posedge clk_sys);
		cmpValid <= 0;
		#1;
	endtask

	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		repeat (8) @(posedge clk_sys);
		reset_n <= 1;
		foreach (RA[i]) rd(RA[i], RV[i]);
		wr(OFF_R2_HI, 8'hff);
		rd(OFF_R2_HI, 8'h0f);
		chk(secondRefDivide, 12'hf02);
		wr(OFF_THR_HI, 8'hff);
		rd(OFF_THR_HI, 8'h3f);
		wr(OFF_THR_HI, 8'h00);
		wr(OFF_THR_LO, 8'h02);
		// threshold two: every window code, loss restarts the count
		foreach (LK[i]) begin
			wr(OFF_WINDOW, {6'h00, LK[i][10:9]});
			cmp(LK[i][8:1]);
			chk(firstLock, LK[i][0]);
		end
		// holdover exit at offsets -2, +2 and 0: fb minus ref restart time equals the offset
		for (int k = 0; k < 3; k++) begin
			wr(OFF_EXIT_ADJ, (k == 0) ? 8'h1e : (k == 1) ? 8'h02 : 8'h00);
			@(posedge clk_sys);
			holdoverActive <= 1;
			repeat (2) @(posedge clk_sys);
			holdoverActive <= 0;
			{tf, tr, nf, nr} = '0;
			for (int i = 1; i < 12; i++) begin
				@(posedge clk_sys);
				#1;
				nf += (firstFbReset === 1'b1);
				nr += (firstRefReset === 1'b1);
				if (firstFbReset === 1'b1)
					tf = i;
				if (firstRefReset === 1'b1)
					tr = i;
			end
			chk(12'(tf - tr), (k == 0) ? 12'hffe : (k == 1) ? 12'h002 : 12'h000);
			chk(12'(nf * 16 + nr), 12'h011);
		end
		// pin sources and modes; the partner drives only in the plain input mode
		foreach (PT[i]) begin
			@(posedge clk_sys);
			driveEn <= (PT[i][2:0] == 3'h0);
			wr(OFF_PIN_CFG, PT[i][7:0]);
			repeat (3) @(posedge clk_sys);
			#1 chk(pinLevel, PT[i][8]);
			chk(thirdClockLos, (PT[i][2:0] < 3'h3) ? PT[i][8] : 1'b0);
			chk({pinPullUp, pinPullDown}, {PT[i][2:0] == 3'h1, PT[i][2:0] == 3'h2});
		end
		// a real rising feedback tap edge flips its half tap
		wr(OFF_PIN_CFG, 8'h63);
		@(posedge clk_sys) firstFbTap <= 0;
		@(posedge clk_sys) firstFbTap <= 1;
		repeat (3) @(posedge clk_sys);
		#1 chk(pinLevel, 1'b1);
		// events: raised, masked, unmasked, cleared
		rd(OFF_IRQ_STAT, 8'h0f);
		chk(irq, 1'b0);
		wr(OFF_IRQ_MASK, 8'h08);
		#1 chk(irq, 1'b1);
		wr(OFF_IRQ_STAT, 8'h08);
		#1 chk(irq, 1'b0);
		rd(OFF_IRQ_STAT, 8'h07);
		print_verdict();
	end
endmodule
`default_nettype wire
